/* design/eadc_defs.svh */
`ifndef EADC_DEFS_SVH
`define EADC_DEFS_SVH

// effective-address field positions in the operation word
`define EADC_EA_MODE_MSB 5
`define EADC_EA_MODE_LSB 3
`define EADC_EA_REG_MSB 2
`define EADC_EA_REG_LSB 0

// mode field codes
`define EADC_MF_DREG 3'h0
`define EADC_MF_AREG 3'h1
`define EADC_MF_IND 3'h2
`define EADC_MF_POST 3'h3
`define EADC_MF_PRE 3'h4
`define EADC_MF_D16 3'h5
`define EADC_MF_IDX 3'h6
`define EADC_MF_EXT 3'h7

// register field codes under mode 111
`define EADC_RF_ABSW 3'h0
`define EADC_RF_ABSL 3'h1
`define EADC_RF_PCD 3'h2
`define EADC_RF_PCI 3'h3
`define EADC_RF_IMM 3'h4

// brief extension word layout
`define EADC_IDX_DA_BIT 15
`define EADC_IDX_REG_MSB 14
`define EADC_IDX_REG_LSB 12
`define EADC_IDX_SC_MSB 10
`define EADC_IDX_SC_LSB 9
`define EADC_IDX_D8_MSB 7

// trap opcode: upper twelve bits, vector in the low four
`define EADC_TRAP_OP 12'h4e4
`define EADC_TRAP_VEC_W 4
// multiply-accumulate opcode line
`define EADC_MAC_LINE 4'ha
// long multiply opcode, extension bit that asks for a 64-bit result
`define EADC_MULL_OP 10'h130
`define EADC_MULL_64_BIT 10

// status word
`define EADC_SR_RESET 16'h2700
`define EADC_CCR_W 8

// pc-relative base lies one word past the operation word
`define EADC_PC_EXT_OFS 32'h0000_0002
// low half offsets inside a big-endian operand
`define EADC_LO_WORD_OFS 32'h0000_0002
`define EADC_LO_BYTE_OFS 32'h0000_0001

`endif

/* design/eadc_pkg.sv */
package eadc_pkg;

  typedef enum logic [1:0] {
    EADC_SZ_BYTE = 2'b00,
    EADC_SZ_WORD = 2'b01,
    EADC_SZ_LONG = 2'b10
  } eadc_size_t;

  typedef enum logic [3:0] {
    EADC_M_DREG = 4'b0000,
    EADC_M_AREG = 4'b0001,
    EADC_M_IND = 4'b0010,
    EADC_M_POST = 4'b0011,
    EADC_M_PRE = 4'b0100,
    EADC_M_D16 = 4'b0101,
    EADC_M_IDX = 4'b0110,
    EADC_M_PCD = 4'b0111,
    EADC_M_PCI = 4'b1000,
    EADC_M_ABSW = 4'b1001,
    EADC_M_ABSL = 4'b1010,
    EADC_M_IMM = 4'b1011,
    EADC_M_BAD = 4'b1111
  } eadc_mode_t;

  typedef enum logic [1:0] {
    EADC_S_IDLE = 2'b00,
    EADC_S_EXT = 2'b01,
    EADC_S_READ = 2'b10,
    EADC_S_CALC = 2'b11
  } eadc_state_t;

  typedef struct packed {
    logic data;
    logic memory;
    logic control;
    logic alterable;
    logic alt_mem;
    logic data_alt;
  } eadc_cat_t;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
    eadc_size_t size;
    logic [31:0] pc;
  } eadc_fetch_t;

  typedef struct packed {
    logic en;
    logic [3:0] addr;
    logic [31:0] data;
  } eadc_regwr_t;

  typedef struct packed {
    logic word_en;
    logic byte_en;
    logic [15:0] data;
  } eadc_pswwr_t;

  typedef struct packed {
    logic valid;
    eadc_mode_t mode;
    eadc_cat_t cat;
    logic is_mem;
    logic is_reg;
    logic is_imm;
    logic [31:0] addr;
    logic [31:0] lo_addr;
    logic [31:0] value;
  } eadc_result_t;

  typedef struct packed {
    logic valid;
    logic trap;
    logic [3:0] trap_vec;
    logic mac;
    logic unsupported;
  } eadc_opinfo_t;

endpackage

/* design/eadc_regfile.sv */
`timescale 1ns/10ps
module eadc_regfile #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 32,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_a_addr,
  input wire logic [AW-1:0] rd_b_addr,
  output logic [WIDTH-1:0] rd_a_data,
  output logic [WIDTH-1:0] rd_b_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // registered read ports
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end else begin
      rd_a_data <= mem_q[rd_a_addr];
      rd_b_data <= mem_q[rd_b_addr];
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end
endmodule

/* design/eadc_decoder.sv */
`timescale 1ns/10ps
`include "eadc_defs.svh"
module eadc_decoder
  import eadc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input eadc_fetch_t fetch,
  output logic fetch_ready,
  input eadc_regwr_t reg_wr,
  input eadc_pswwr_t psw_wr,
  output eadc_result_t result,
  output eadc_regwr_t reg_upd,
  output eadc_opinfo_t op_info,
  output logic [15:0] proc_status_word,
  output logic [7:0] cond_flags_byte
);

  typedef struct packed {
    eadc_state_t st;
    logic rdy;
    logic [15:0] op;
    eadc_size_t size;
    logic [31:0] pc;
    eadc_mode_t mode;
    logic [1:0] words_left;
    logic mulchk;
    logic [31:0] ext;
    eadc_result_t res;
    eadc_regwr_t upd;
    eadc_opinfo_t info;
    logic [15:0] psw;
  } eadc_reg_t;

  eadc_reg_t s_q;
  eadc_reg_t s_d;
  logic [31:0] rd_a;
  logic [31:0] rd_b;
  logic [3:0] rd_a_addr;
  logic [3:0] rd_b_addr;

  function automatic eadc_mode_t mode_of(input logic [5:0] ea);
    logic [2:0] mf;
    logic [2:0] rf;
    eadc_mode_t m;
    mf = ea[`EADC_EA_MODE_MSB:`EADC_EA_MODE_LSB];
    rf = ea[`EADC_EA_REG_MSB:`EADC_EA_REG_LSB];
    m = EADC_M_BAD;
    unique case (mf)
      `EADC_MF_DREG: m = EADC_M_DREG;
      `EADC_MF_AREG: m = EADC_M_AREG;
      `EADC_MF_IND: m = EADC_M_IND;
      `EADC_MF_POST: m = EADC_M_POST;
      `EADC_MF_PRE: m = EADC_M_PRE;
      `EADC_MF_D16: m = EADC_M_D16;
      `EADC_MF_IDX: m = EADC_M_IDX;
      `EADC_MF_EXT: begin
        unique case (rf)
          `EADC_RF_PCD: m = EADC_M_PCD;
          `EADC_RF_PCI: m = EADC_M_PCI;
          `EADC_RF_ABSW: m = EADC_M_ABSW;
          `EADC_RF_ABSL: m = EADC_M_ABSL;
          `EADC_RF_IMM: m = EADC_M_IMM;
          default: m = EADC_M_BAD;
        endcase
      end
    endcase
    return m;
  endfunction

  function automatic eadc_cat_t cat_of(input eadc_mode_t m);
    eadc_cat_t c;
    c = '0;
    unique case (m)
      EADC_M_DREG: c = '{data: 1'b1, alterable: 1'b1, default: 1'b0};
      EADC_M_AREG: c = '{alterable: 1'b1, default: 1'b0};
      EADC_M_IND, EADC_M_D16, EADC_M_IDX: c = '{default: 1'b1};
      EADC_M_POST, EADC_M_PRE: c = '{control: 1'b0, default: 1'b1};
      EADC_M_PCD, EADC_M_PCI, EADC_M_ABSW, EADC_M_ABSL:
        c = '{data: 1'b1, memory: 1'b1, control: 1'b1, default: 1'b0};
      EADC_M_IMM: c = '{data: 1'b1, memory: 1'b1, default: 1'b0};
      default: c = '0;
    endcase
    c.alt_mem = c.alterable & c.memory;
    c.data_alt = c.data & c.alterable;
    return c;
  endfunction

  function automatic logic [1:0] ext_words(input eadc_mode_t m, input eadc_size_t sz);
    logic [1:0] n;
    n = 2'h0;
    unique case (m)
      EADC_M_D16, EADC_M_IDX, EADC_M_PCD, EADC_M_PCI, EADC_M_ABSW: n = 2'h1;
      EADC_M_ABSL: n = 2'h2;
      EADC_M_IMM: n = (sz == EADC_SZ_LONG) ? 2'h2 : 2'h1;
      default: n = 2'h0;
    endcase
    return n;
  endfunction

  function automatic logic removed_op(input logic [15:0] op);
    logic bcd;
    logic bfld;
    logic rot;
    logic dbra;
    bcd = ((op[15:12] == 4'hc) || (op[15:12] == 4'h8)) && (op[8:4] == 5'h10);
    bfld = (op[15:11] == 5'h1d) && (op[7:6] == 2'h3);
    rot = (op[15:12] == 4'he) && (((op[7:6] != 2'h3) && (op[4:3] == 2'h3)) ||
          ((op[7:6] == 2'h3) && (op[11:9] == 3'h3)));
    dbra = (op[15:12] == 4'h5) && (op[7:3] == 5'h19);
    return bcd | bfld | rot | dbra;
  endfunction

  function automatic logic [31:0] size_bytes(input eadc_size_t sz);
    logic [31:0] b;
    b = 32'h0000_0001;
    unique case (sz)
      EADC_SZ_BYTE: b = 32'h0000_0001;
      EADC_SZ_WORD: b = 32'h0000_0002;
      EADC_SZ_LONG: b = 32'h0000_0004;
      default: b = 32'h0000_0001;
    endcase
    return b;
  endfunction

  always_comb begin
    logic [31:0] d16;
    logic [31:0] d8;
    logic [31:0] idx;
    logic [31:0] base;
    logic [31:0] ea;
    logic [1:0] sc;
    eadc_mode_t m;
    s_d = s_q;
    s_d.res.valid = 1'b0;
    s_d.upd.en = 1'b0;
    s_d.info.valid = 1'b0;
    d16 = {{16{s_q.ext[15]}}, s_q.ext[15:0]};
    d8 = {{24{s_q.ext[`EADC_IDX_D8_MSB]}}, s_q.ext[7:0]};
    sc = s_q.ext[`EADC_IDX_SC_MSB:`EADC_IDX_SC_LSB];
    idx = (sc == 2'h3) ? rd_b : (rd_b << sc);
    base = (s_q.mode == EADC_M_PCD || s_q.mode == EADC_M_PCI) ? (s_q.pc + `EADC_PC_EXT_OFS) : rd_a;
    ea = base;
    m = mode_of(fetch.word[5:0]);

    unique case (s_q.st)
      EADC_S_IDLE: begin
        if (fetch.valid) begin
          s_d.op = fetch.word;
          s_d.size = fetch.size;
          s_d.pc = fetch.pc;
          s_d.mode = m;
          s_d.ext = '0;
          s_d.info.valid = 1'b1;
          s_d.info.trap = (fetch.word[15:4] == `EADC_TRAP_OP);
          s_d.info.trap_vec = fetch.word[`EADC_TRAP_VEC_W-1:0];
          s_d.info.mac = (fetch.word[15:12] == `EADC_MAC_LINE);
          s_d.info.unsupported = removed_op(fetch.word);
          s_d.mulchk = (fetch.word[15:6] == `EADC_MULL_OP);
          s_d.words_left = ext_words(m, fetch.size);
          if (removed_op(fetch.word) || s_d.info.trap || s_d.info.mac) begin
            s_d.st = EADC_S_IDLE;
          end else if (s_d.mulchk || s_d.words_left != 2'h0) begin
            s_d.st = EADC_S_EXT;
          end else begin
            s_d.st = EADC_S_READ;
          end
        end
      end
      EADC_S_EXT: begin
        if (fetch.valid) begin
          if (s_q.mulchk) begin
            s_d.mulchk = 1'b0;
            if (fetch.word[`EADC_MULL_64_BIT]) begin
              s_d.info.valid = 1'b1;
              s_d.info.unsupported = 1'b1;
              s_d.st = EADC_S_IDLE;
            end else if (s_q.words_left == 2'h0) begin
              s_d.st = EADC_S_READ;
            end
          end else begin
            s_d.ext = {s_q.ext[15:0], fetch.word};
            s_d.words_left = s_q.words_left - 2'h1;
            if (s_q.words_left == 2'h1) begin
              s_d.st = EADC_S_READ;
            end
          end
        end
      end
      EADC_S_READ: begin
        s_d.st = EADC_S_CALC;
      end
      EADC_S_CALC: begin
        unique case (s_q.mode)
          EADC_M_PRE: ea = rd_a - size_bytes(s_q.size);
          EADC_M_D16, EADC_M_PCD: ea = base + d16;
          EADC_M_IDX, EADC_M_PCI: ea = base + d8 + idx;
          EADC_M_ABSW: ea = d16;
          EADC_M_ABSL: ea = s_q.ext;
          default: ea = base;
        endcase
        s_d.res.valid = 1'b1;
        s_d.res.mode = s_q.mode;
        s_d.res.cat = cat_of(s_q.mode);
        s_d.res.is_reg = (s_q.mode == EADC_M_DREG) || (s_q.mode == EADC_M_AREG);
        s_d.res.is_imm = (s_q.mode == EADC_M_IMM);
        s_d.res.is_mem = !s_d.res.is_reg && !s_d.res.is_imm && (s_q.mode != EADC_M_BAD);
        s_d.res.addr = s_d.res.is_mem ? ea : '0;
        s_d.res.lo_addr = '0;
        if (s_d.res.is_mem && s_q.size == EADC_SZ_LONG) begin
          s_d.res.lo_addr = ea + `EADC_LO_WORD_OFS;
        end else if (s_d.res.is_mem && s_q.size == EADC_SZ_WORD) begin
          s_d.res.lo_addr = ea + `EADC_LO_BYTE_OFS;
        end
        unique case (s_q.size)
          EADC_SZ_BYTE: s_d.res.value = {24'h00_0000, s_q.ext[7:0]};
          EADC_SZ_WORD: s_d.res.value = {16'h0000, s_q.ext[15:0]};
          default: s_d.res.value = s_q.ext;
        endcase
        if (s_d.res.is_reg) begin
          s_d.res.value = rd_a;
        end else if (!s_d.res.is_imm) begin
          s_d.res.value = '0;
        end
        if (s_q.mode == EADC_M_POST || s_q.mode == EADC_M_PRE) begin
          s_d.upd.en = 1'b1;
          s_d.upd.addr = {1'b1, s_q.op[`EADC_EA_REG_MSB:`EADC_EA_REG_LSB]};
          s_d.upd.data = (s_q.mode == EADC_M_PRE) ? ea : (rd_a + size_bytes(s_q.size));
        end
        s_d.st = EADC_S_IDLE;
      end
    endcase
    s_d.rdy = (s_d.st == EADC_S_IDLE) || (s_d.st == EADC_S_EXT);

    if (psw_wr.word_en) begin
      s_d.psw = psw_wr.data;
    end else if (psw_wr.byte_en) begin
      s_d.psw[`EADC_CCR_W-1:0] = psw_wr.data[`EADC_CCR_W-1:0];
    end
  end

  // base register: data or address bank from mode; index bank from extension word
  assign rd_a_addr = {(s_q.mode != EADC_M_DREG), s_q.op[`EADC_EA_REG_MSB:`EADC_EA_REG_LSB]};
  assign rd_b_addr = {s_q.ext[`EADC_IDX_DA_BIT], s_q.ext[`EADC_IDX_REG_MSB:`EADC_IDX_REG_LSB]};

  eadc_regfile #(
    .DEPTH(16),
    .WIDTH(32),
    .AW(4)
  ) u_regs (
    .clk(clk),
    .resetn(resetn),
    .wr_en(reg_wr.en),
    .wr_addr(reg_wr.addr),
    .wr_data(reg_wr.data),
    .rd_a_addr(rd_a_addr),
    .rd_b_addr(rd_b_addr),
    .rd_a_data(rd_a),
    .rd_b_data(rd_b)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.st <= EADC_S_IDLE;
      s_q.rdy <= 1'b1;
      s_q.mode <= EADC_M_BAD;
      s_q.psw <= `EADC_SR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign fetch_ready = s_q.rdy;
  assign result = s_q.res;
  assign reg_upd = s_q.upd;
  assign op_info = s_q.info;
  assign proc_status_word = s_q.psw;
  assign cond_flags_byte = s_q.psw[`EADC_CCR_W-1:0];
endmodule

/* testbench/eadc_decoder_assertions.sv */
`timescale 1ns/10ps
`include "eadc_defs.svh"
module eadc_decoder_assertions
  import eadc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input eadc_fetch_t fetch,
  input wire logic fetch_ready,
  input eadc_regwr_t reg_wr,
  input eadc_pswwr_t psw_wr,
  input eadc_result_t result,
  input eadc_regwr_t reg_upd,
  input eadc_opinfo_t op_info,
  input wire logic [15:0] proc_status_word,
  input wire logic [7:0] cond_flags_byte
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic exp_op_q;
  eadc_size_t sz_q;
  wire logic end_evt = result.valid || (op_info.valid && (op_info.trap || op_info.mac || op_info.unsupported));
  wire logic op_take = fetch.valid && fetch_ready && (exp_op_q || end_evt);
  // tracks which taken word is an operation word
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exp_op_q <= 1'b1;
      sz_q <= EADC_SZ_BYTE;
    end else if (op_take) begin
      exp_op_q <= 1'b0;
      sz_q <= fetch.size;
    end else if (end_evt) begin
      exp_op_q <= 1'b1;
    end
  end
  function automatic logic [3:0] cat_of(input eadc_mode_t m);
    case (m)
      EADC_M_DREG: cat_of = 4'h9;
      EADC_M_AREG: cat_of = 4'h1;
      EADC_M_IND, EADC_M_D16, EADC_M_IDX: cat_of = 4'hf;
      EADC_M_POST, EADC_M_PRE: cat_of = 4'hd;
      EADC_M_PCD, EADC_M_PCI, EADC_M_ABSW, EADC_M_ABSL: cat_of = 4'he;
      EADC_M_IMM: cat_of = 4'hc;
      default: cat_of = 4'h0;
    endcase
  endfunction
  sequence simple_op_s;
    op_take && fetch.word[5:3] inside {3'h2, 3'h3, 3'h4} && fetch.word[15:4] != `EADC_TRAP_OP &&
      fetch.word[15:12] != `EADC_MAC_LINE;
  endsequence
  sequence answer_s;
    op_info.valid && !fetch_ready ##1 !fetch_ready ##1
      (result.valid && result.mode inside {EADC_M_IND, EADC_M_POST, EADC_M_PRE});
  endsequence
  simple_answer_a: assert property (simple_op_s |=> answer_s)
    else $error("simple mode answer wrong");
  mode_cat_a: assert property (result.valid |->
    {result.cat.data, result.cat.memory, result.cat.control, result.cat.alterable} == cat_of(result.mode))
    else $error("mode category wrong");
  class_combo_a: assert property (result.valid |-> result.cat.alt_mem == (result.cat.alterable &&
    result.cat.memory) && result.cat.data_alt == (result.cat.data && result.cat.alterable))
    else $error("combined class wrong");
  long_low_a: assert property (result.valid && result.is_mem && !result.is_imm && sz_q == EADC_SZ_LONG
    |-> result.lo_addr == result.addr + `EADC_LO_WORD_OFS) else $error("long low word address wrong");
  word_low_a: assert property (result.valid && result.is_mem && !result.is_imm && sz_q == EADC_SZ_WORD
    |-> result.lo_addr == result.addr + `EADC_LO_BYTE_OFS) else $error("word low byte address wrong");
  trap_vec_a: assert property (op_take && fetch.word[15:4] == `EADC_TRAP_OP |=> op_info.valid &&
    op_info.trap && op_info.trap_vec == $past(fetch.word[3:0])) else $error("trap vector wrong");
  mac_flag_a: assert property (op_take && fetch.word[15:12] == `EADC_MAC_LINE |=>
    op_info.valid && op_info.mac ##1 !result.valid[*3]) else $error("mac op not flagged");
  flag_mirror_a: assert property (cond_flags_byte == proc_status_word[7:0])
    else $error("flag byte differs from status word");
  byte_write_a: assert property (psw_wr.byte_en && !psw_wr.word_en |=>
    cond_flags_byte == $past(psw_wr.data[7:0]) && $stable(proc_status_word[15:8]))
    else $error("flag byte write wrong");
  word_write_a: assert property (psw_wr.word_en |=> proc_status_word == $past(psw_wr.data))
    else $error("status word write wrong");
endmodule

bind eadc_decoder eadc_decoder_assertions u_chk (.clk(clk), .resetn(resetn), .fetch(fetch),
  .fetch_ready(fetch_ready), .reg_wr(reg_wr), .psw_wr(psw_wr), .result(result), .reg_upd(reg_upd),
  .op_info(op_info), .proc_status_word(proc_status_word), .cond_flags_byte(cond_flags_byte));

/* testbench/eadc_stream_model.sv */
`timescale 1ns/10ps
module eadc_stream_model
  import eadc_pkg::*;
(
  input wire logic clk,
  input wire logic fetch_ready,
  output eadc_fetch_t fetch
);
  eadc_fetch_t q[$];
  logic gap = 1'b0;
  logic hold = 1'b0;
  initial fetch = '0;
  // words leave in the order queued, extension words after their op
  task automatic push(input eadc_fetch_t f);
    q.push_back(f);
  endtask
  always @(posedge clk) begin
    if (fetch.valid && fetch_ready) begin
      void'(q.pop_front());
      hold <= gap;
    end else begin
      hold <= 1'b0;
    end
  end
  // idle word lines toggle instead of holding old value
  always @(negedge clk) begin
    if (q.size() > 0 && !hold) begin
      fetch <= q[0];
    end else begin
      fetch <= '{1'b0, ~fetch.word, fetch.size, ~fetch.pc};
    end
  end
endmodule

/* testbench/effective_address_decoder_bench.sv */
`timescale 1ns/10ps
module effective_address_decoder_bench;
  import eadc_pkg::*;
  logic clk;
  logic resetn;
  eadc_fetch_t fetch;
  logic fetch_ready;
  eadc_regwr_t reg_wr;
  eadc_regwr_t reg_upd;
  eadc_pswwr_t psw_wr;
  eadc_result_t result;
  eadc_opinfo_t op_info;
  logic [15:0] proc_status_word;
  logic [7:0] cond_flags_byte;
  logic [31:0] upd_q = '0;
  logic [3:0] upd_a_q = '0;
  int miscompares = 0;
  int tests_run = 0;
  eadc_decoder DUT (.clk(clk), .resetn(resetn), .fetch(fetch), .fetch_ready(fetch_ready),
    .reg_wr(reg_wr), .psw_wr(psw_wr), .result(result), .reg_upd(reg_upd), .op_info(op_info),
    .proc_status_word(proc_status_word), .cond_flags_byte(cond_flags_byte));
  eadc_stream_model fm (.clk(clk), .fetch_ready(fetch_ready), .fetch(fetch));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (reg_upd.en === 1'b1) begin
      upd_q <= reg_upd.data;
      upd_a_q <= reg_upd.addr;
    end
  end
  task automatic print_verdict;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_for(input int k);
    tests_run++;
    for (int i = 0; i < 30; i++) begin
      @(posedge clk);
      #1;
      if ((k == 0 ? result.valid : k == 1 ? op_info.valid : op_info.valid & op_info.unsupported) === 1'b1) return;
    end
    miscompares++;
    $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    print_verdict();
  endtask
  task automatic push_w(input logic [15:0] w, input eadc_size_t sz);
    fm.push('{1'b1, w, sz, 32'h0000_4000});
  endtask
  task automatic run_ea(input logic [15:0] op, w1, w2, input eadc_size_t sz, input int n,
                        input eadc_mode_t m, input logic [31:0] a);
    logic [31:0] exp_kind;
    @(posedge clk);
    #1;
    push_w(op, sz);
    if (n > 0) push_w(w1, sz);
    if (n > 1) push_w(w2, sz);
    wait_for(0);
    check(32'(result.mode), 32'(m));
    exp_kind = (m < EADC_M_IND) ? 32'h4 : (m == EADC_M_IMM) ? 32'h2 : (m == EADC_M_BAD) ? 32'h0 : 32'h1;
    check(32'({result.is_reg, result.is_imm, result.is_mem}), exp_kind);
    if (m > EADC_M_AREG && m < EADC_M_IMM) begin
      check(result.addr, a);
      check(result.lo_addr, sz == EADC_SZ_LONG ? a + 32'h2 : a + 32'h1);
    end
  endtask
  task automatic reg_write(input logic [3:0] ad, input logic [31:0] d);
    @(negedge clk);
    reg_wr <= '{1'b1, ad, d};
    @(negedge clk);
    reg_wr <= '0;
  endtask
  task automatic psw_write(input logic [1:0] we, input logic [15:0] d);
    @(negedge clk);
    psw_wr <= '{we[1], we[0], d};
    @(negedge clk);
    psw_wr <= '0;
  endtask
  task automatic t_psw;
    check(32'(proc_status_word), 32'h2700);
    check(32'(cond_flags_byte), 32'h0);
    psw_write(2'b01, 16'h00a5);
    check(32'(proc_status_word), 32'h27a5);
    psw_write(2'b10, 16'h2715);
    check(32'(cond_flags_byte), 32'h15);
    $display("test psw done");
  endtask
  task automatic t_modes;
    reg_write(4'ha, 32'h1000_0100);
    reg_write(4'h3, 32'h0000_0010);
    reg_write(4'hd, 32'h2000_0000);
    run_ea(16'h0003, 0, 0, EADC_SZ_LONG, 0, EADC_M_DREG, 0);
    check(result.value, 32'h0000_0010);
    run_ea(16'h000a, 0, 0, EADC_SZ_LONG, 0, EADC_M_AREG, 0);
    check(result.value, 32'h1000_0100);
    run_ea(16'h0012, 0, 0, EADC_SZ_WORD, 0, EADC_M_IND, 32'h1000_0100);
    run_ea(16'h0012, 0, 0, EADC_SZ_LONG, 0, EADC_M_IND, 32'h1000_0100);
    run_ea(16'h002a, 16'hfffe, 0, EADC_SZ_WORD, 1, EADC_M_D16, 32'h1000_00fe);
    run_ea(16'h0032, 16'h3cfc, 0, EADC_SZ_LONG, 1, EADC_M_IDX, 32'h1000_013c);
    run_ea(16'h0032, 16'hda10, 0, EADC_SZ_LONG, 1, EADC_M_IDX, 32'h5000_0110);
    run_ea(16'h003a, 16'h0010, 0, EADC_SZ_WORD, 1, EADC_M_PCD, 32'h0000_4012);
    run_ea(16'h003b, 16'h3800, 0, EADC_SZ_WORD, 1, EADC_M_PCI, 32'h0000_4012);
    run_ea(16'h0038, 16'h0200, 0, EADC_SZ_WORD, 1, EADC_M_ABSW, 32'h0000_0200);
    fm.gap = 1'b1;
    run_ea(16'h0039, 16'h1234, 16'h5678, EADC_SZ_LONG, 2, EADC_M_ABSL, 32'h1234_5678);
    run_ea(16'h003c, 16'h1234, 16'h5678, EADC_SZ_LONG, 2, EADC_M_IMM, 0);
    check(result.value, 32'h1234_5678);
    fm.gap = 1'b0;
    run_ea(16'h003c, 16'h12a5, 0, EADC_SZ_BYTE, 1, EADC_M_IMM, 0);
    check(result.value, 32'h0000_00a5);
    run_ea(16'h003d, 0, 0, EADC_SZ_WORD, 0, EADC_M_BAD, 0);
    run_ea(16'h001a, 0, 0, EADC_SZ_LONG, 0, EADC_M_POST, 32'h1000_0100);
    run_ea(16'h0003, 0, 0, EADC_SZ_LONG, 0, EADC_M_DREG, 0);
    check(upd_q, 32'h1000_0104);
    check(32'(upd_a_q), 32'h0000_000a);
    reg_write(4'ha, 32'h1000_0104);
    run_ea(16'h0022, 0, 0, EADC_SZ_WORD, 0, EADC_M_PRE, 32'h1000_0102);
    $display("test modes done");
  endtask
  task automatic t_ops;
    for (int v = 0; v < 16; v++) begin
      @(posedge clk);
      #1;
      push_w(16'h4e40 | 16'(v), EADC_SZ_WORD);
      wait_for(1);
      check(32'(op_info.trap), 32'h1);
      check(32'(op_info.trap_vec), 32'(v));
    end
    @(posedge clk);
    #1;
    push_w(16'ha000, EADC_SZ_LONG);
    wait_for(1);
    check(32'(op_info.mac), 32'h1);
    @(posedge clk);
    #1;
    push_w(16'h4c00, EADC_SZ_LONG);
    push_w(16'h0400, EADC_SZ_LONG);
    wait_for(2);
    @(posedge clk);
    #1;
    push_w(16'h51c8, EADC_SZ_WORD);
    wait_for(2);
    $display("test ops done");
  endtask
  initial begin
    resetn = 1'b0;
    reg_wr = '0;
    psw_wr = '0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    t_psw();
    t_modes();
    t_ops();
    print_verdict();
  end
endmodule
